//--- rtl/rxflag_pkg.sv
// Purpose: Shared constants and types for the receiver flag and interrupt enable block.
// Assumes: 32-bit APB, one register per aligned word.
// Notes:   Offsets are chosen locally; both registers are 8 bits wide in the low lane.
package rxflag_pkg;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam logic [7:0] FLAGS_OFFSET   = 8'h00;
    localparam logic [7:0] ENABLES_OFFSET = 8'h04;
    localparam logic [7:0] FLAGS_RESET    = 8'h00;
    localparam logic [7:0] ENABLES_RESET  = 8'h00;

    // ========================================================================
    // Bit positions
    // ========================================================================
    localparam int WAKEUP_BIT    = 7;
    localparam int CHANGE_BIT    = 6;
    localparam int RXSTATE_LSB   = 4;
    localparam int TXSTATE_LSB   = 2;
    localparam int OVERRUN_BIT   = 1;
    localparam int RXFULL_BIT    = 0;

    // ========================================================================
    // Error counter thresholds
    // ========================================================================
    localparam logic [8:0] WARN_LIMIT = 9'h060;
    localparam logic [8:0] ERR_LIMIT  = 9'h07f;
    localparam logic [8:0] OFF_LIMIT  = 9'h0ff;

    localparam logic [1:0] STATE_OK   = 2'h0;
    localparam logic [1:0] STATE_WARN = 2'h1;
    localparam logic [1:0] STATE_ERR  = 2'h2;
    localparam logic [1:0] STATE_OFF  = 2'h3;

    localparam logic [1:0] SENS_NEVER = 2'h0;
    localparam logic [1:0] SENS_OFF   = 2'h1;
    localparam logic [1:0] SENS_ERR   = 2'h2;

    typedef struct packed {
        logic       wakeup_flag;
        logic       bus_status_change_flag;
        logic [1:0] receiver_state_field;
        logic [1:0] transmitter_state_field;
        logic       overrun_flag;
        logic       receive_buffer_full_flag;
    } flags_type;

    typedef struct packed {
        logic       wakeup_irq_enable;
        logic       bus_status_change_irq_enable;
        logic [1:0] receiver_state_sensitivity;
        logic [1:0] transmitter_state_sensitivity;
        logic       overrun_irq_enable;
        logic       receive_full_irq_enable;
    } enables_type;

    typedef struct packed {
        flags_type   flags;
        enables_type enables;
        logic [31:0] prdata;
    } state_type;

endpackage : rxflag_pkg

//--- rtl/can_rx_flags_and_irq_enables.sv
// Purpose: Receiver flag and receiver interrupt enable registers of a CAN controller.
// Assumes: Error counters, FIFO events and init handshake come from neighbouring logic.
// Notes:   Zero-wait APB slave; unmapped addresses read zero and drop writes.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ns

module can_rx_flags_and_irq_enables (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0] pstrb,
    output logic      [31:0] prdata,
    output logic            pready,
    output logic            pslverr,
    input  wire logic       init_mode_request,
    input  wire logic       init_mode_acknowledge,
    input  wire logic [8:0] tx_error_count,
    input  wire logic [8:0] rx_error_count,
    input  wire logic       wakeup_event,
    input  wire logic       overrun_event,
    input  wire logic       message_shift,
    input  wire logic       message_correct,
    output logic            fifo_advance_allow,
    output logic            wakeup_irq,
    output logic            error_irq,
    output logic            receive_irq
);

    // ========================================================================
    // State classification
    // ========================================================================
    function automatic logic [1:0] tx_class(input logic [8:0] cnt);
        if (cnt > rxflag_pkg::OFF_LIMIT) begin
            tx_class = rxflag_pkg::STATE_OFF;
        end else if (cnt > rxflag_pkg::ERR_LIMIT) begin
            tx_class = rxflag_pkg::STATE_ERR;
        end else if (cnt > rxflag_pkg::WARN_LIMIT) begin
            tx_class = rxflag_pkg::STATE_WARN;
        end else begin
            tx_class = rxflag_pkg::STATE_OK;
        end
    endfunction : tx_class

    // Sensitivity decides whether a move from a to b is worth a change flag.
    function automatic logic sens_hit(input logic [1:0] s, input logic [1:0] a,
                                      input logic [1:0] b);
        logic off_move;
        logic err_move;
        off_move = (a == rxflag_pkg::STATE_OFF) != (b == rxflag_pkg::STATE_OFF);
        err_move = (a[1]) != (b[1]);
        if (a == b) begin
            sens_hit = 1'b0;
        end else if (s == rxflag_pkg::SENS_NEVER) begin
            sens_hit = 1'b0;
        end else if (s == rxflag_pkg::SENS_OFF) begin
            sens_hit = off_move;
        end else if (s == rxflag_pkg::SENS_ERR) begin
            sens_hit = err_move | off_move;
        end else begin
            sens_hit = 1'b1;
        end
    endfunction : sens_hit

    rxflag_pkg::state_type state_q;
    rxflag_pkg::state_type state_d;

    logic       in_init;
    logic       wr_access;
    logic       rd_setup;
    logic [1:0] tx_now;
    logic [1:0] rx_now;
    logic       change_event;
    logic       hit_flags;
    logic       hit_enables;

    assign in_init     = init_mode_request & init_mode_acknowledge;
    assign wr_access   = psel & penable & pwrite & pstrb[0];
    assign rd_setup    = psel & ~penable & ~pwrite;
    assign hit_flags   = (paddr == rxflag_pkg::FLAGS_OFFSET);
    assign hit_enables = (paddr == rxflag_pkg::ENABLES_OFFSET);
    assign tx_now      = tx_class(tx_error_count);
    // Bus-off of the transmitter overrides the receiver; leaving it lands at the counter class.
    assign rx_now      = (tx_now == rxflag_pkg::STATE_OFF) ? rxflag_pkg::STATE_OFF :
                         (rx_error_count > rxflag_pkg::ERR_LIMIT) ? rxflag_pkg::STATE_ERR :
                         (rx_error_count > rxflag_pkg::WARN_LIMIT) ? rxflag_pkg::STATE_WARN :
                         rxflag_pkg::STATE_OK;

    // Hidden change is only scanned while no change flag is pending.
    assign change_event = ~in_init & ~state_q.flags.bus_status_change_flag &
        (sens_hit(state_q.enables.receiver_state_sensitivity,
                  state_q.flags.receiver_state_field, rx_now) |
         sens_hit(state_q.enables.transmitter_state_sensitivity,
                  state_q.flags.transmitter_state_field, tx_now));

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        state_d = state_q;
        if (rd_setup) begin
            state_d.prdata = 32'h0000_0000;
            if (hit_flags) begin
                state_d.prdata[7:0] = state_q.flags;
            end else if (hit_enables) begin
                state_d.prdata[7:0] = state_q.enables;
            end
        end

        // Status fields track the counters unless a change flag is pending.
        if (~state_q.flags.bus_status_change_flag) begin
            state_d.flags.receiver_state_field    = rx_now;
            state_d.flags.transmitter_state_field = tx_now;
        end

        if (in_init) begin
            // Sticky flags go to reset; status fields keep running.
            state_d.flags.wakeup_flag              = 1'b0;
            state_d.flags.bus_status_change_flag   = 1'b0;
            state_d.flags.overrun_flag             = 1'b0;
            state_d.flags.receive_buffer_full_flag = 1'b0;
            state_d.enables.wakeup_irq_enable            = 1'b0;
            state_d.enables.bus_status_change_irq_enable = 1'b0;
            state_d.enables.overrun_irq_enable           = 1'b0;
            state_d.enables.receive_full_irq_enable      = 1'b0;
        end else begin
            if (wr_access && hit_flags) begin
                // Write one clears; zeros and status positions are ignored.
                if (pwdata[rxflag_pkg::WAKEUP_BIT]) begin
                    state_d.flags.wakeup_flag = 1'b0;
                end
                if (pwdata[rxflag_pkg::CHANGE_BIT]) begin
                    state_d.flags.bus_status_change_flag = 1'b0;
                end
                if (pwdata[rxflag_pkg::OVERRUN_BIT]) begin
                    state_d.flags.overrun_flag = 1'b0;
                end
                if (pwdata[rxflag_pkg::RXFULL_BIT]) begin
                    state_d.flags.receive_buffer_full_flag = 1'b0;
                end
            end
            if (wr_access && hit_enables) begin
                state_d.enables = pwdata[7:0];
            end
            // Events win over a clear in the same cycle.
            if (wakeup_event) begin
                state_d.flags.wakeup_flag = 1'b1;
            end
            if (change_event) begin
                state_d.flags.bus_status_change_flag = 1'b1;
            end
            if (overrun_event) begin
                state_d.flags.overrun_flag = 1'b1;
            end
            if (message_shift && message_correct && fifo_advance_allow) begin
                state_d.flags.receive_buffer_full_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q.flags   <= rxflag_pkg::FLAGS_RESET;
            state_q.enables <= rxflag_pkg::ENABLES_RESET;
            state_q.prdata  <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign prdata  = state_q.prdata;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign fifo_advance_allow = ~state_q.flags.receive_buffer_full_flag;
    assign wakeup_irq  = state_q.flags.wakeup_flag &
                         state_q.enables.wakeup_irq_enable;
    assign error_irq   = (state_q.flags.bus_status_change_flag &
                          state_q.enables.bus_status_change_irq_enable) |
                         (state_q.flags.overrun_flag &
                          state_q.enables.overrun_irq_enable);
    assign receive_irq = state_q.flags.receive_buffer_full_flag &
                         state_q.enables.receive_full_irq_enable;

    // ========================================================================
    // Checks
    // ========================================================================
    a_tx_state_match: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_q.flags.bus_status_change_flag) |->
            state_q.flags.transmitter_state_field == $past(tx_now))
        else $error("transmit state does not match counter at change flag");

    a_state_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        state_q.flags.bus_status_change_flag && $past(state_q.flags.bus_status_change_flag)
            |-> $stable(state_q.flags.receiver_state_field))
        else $error("receiver state moved while change flag pending");

    a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
        (overrun_event && !in_init) |=> state_q.flags.overrun_flag)
        else $error("overrun event did not set flag");

    a_full_set: assert property (@(posedge pclk) disable iff (!presetn)
        (message_shift && message_correct && fifo_advance_allow && !in_init)
            |=> state_q.flags.receive_buffer_full_flag)
        else $error("correct message did not set full flag");

    a_fifo_block: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q.flags.receive_buffer_full_flag && !in_init &&
         !(wr_access && hit_flags && pwdata[rxflag_pkg::RXFULL_BIT]))
            |=> (state_q.flags.receive_buffer_full_flag && !fifo_advance_allow))
        else $error("fifo released without a clear of the full flag");

    a_rx_irq: assert property (@(posedge pclk) disable iff (!presetn)
        receive_irq == (state_q.flags.receive_buffer_full_flag &&
                        state_q.enables.receive_full_irq_enable))
        else $error("receive interrupt does not follow flag and enable");

    a_busoff_rx: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_error_count > rxflag_pkg::OFF_LIMIT && !state_q.flags.bus_status_change_flag)
            |=> state_q.flags.receiver_state_field == rxflag_pkg::STATE_OFF)
        else $error("receiver field not bus-off above 255");

    a_init_enables: assert property (@(posedge pclk) disable iff (!presetn)
        in_init |=> (state_q.enables.wakeup_irq_enable == 1'b0 &&
                     state_q.enables.overrun_irq_enable == 1'b0))
        else $error("enables not held in reset during init");

    a_sens_kept: assert property (@(posedge pclk) disable iff (!presetn)
        in_init |=> $stable(state_q.enables.receiver_state_sensitivity))
        else $error("sensitivity changed in init mode");

    a_clear_one: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_access && hit_flags && !in_init && !pwdata[rxflag_pkg::OVERRUN_BIT] &&
         state_q.flags.overrun_flag) |=> state_q.flags.overrun_flag)
        else $error("writing zero cleared overrun flag");

    a_wake_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !state_q.enables.wakeup_irq_enable |-> !wakeup_irq)
        else $error("wake-up request while masked");

    a_wake_set: assert property (@(posedge pclk) disable iff (!presetn)
        (wakeup_event && !in_init) |=> state_q.flags.wakeup_flag)
        else $error("wake-up event did not set flag");

    a_error_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (!state_q.enables.bus_status_change_irq_enable &&
         !state_q.enables.overrun_irq_enable) |-> !error_irq)
        else $error("error request while both sources masked");

    a_init_flags: assert property (@(posedge pclk) disable iff (!presetn)
        in_init |=> (!state_q.flags.wakeup_flag && !state_q.flags.bus_status_change_flag &&
                     !state_q.flags.overrun_flag && !state_q.flags.receive_buffer_full_flag))
        else $error("sticky flags not held in reset during init");

    a_init_track: assert property (@(posedge pclk) disable iff (!presetn)
        (in_init && !state_q.flags.bus_status_change_flag)
            |=> state_q.flags.transmitter_state_field == $past(tx_now))
        else $error("transmit state stopped following counter in init");

    a_tx_warn: assert property (@(posedge pclk) disable iff (!presetn)
        (!state_q.flags.bus_status_change_flag && tx_error_count > rxflag_pkg::WARN_LIMIT &&
         tx_error_count <= rxflag_pkg::ERR_LIMIT)
            |=> state_q.flags.transmitter_state_field == rxflag_pkg::STATE_WARN)
        else $error("transmit state not warning in warning band");

    a_tx_err: assert property (@(posedge pclk) disable iff (!presetn)
        (!state_q.flags.bus_status_change_flag && tx_error_count > rxflag_pkg::ERR_LIMIT &&
         tx_error_count <= rxflag_pkg::OFF_LIMIT)
            |=> state_q.flags.transmitter_state_field == rxflag_pkg::STATE_ERR)
        else $error("transmit state not error in error band");

    a_rx_ok: assert property (@(posedge pclk) disable iff (!presetn)
        (!state_q.flags.bus_status_change_flag && tx_error_count <= rxflag_pkg::OFF_LIMIT &&
         rx_error_count <= rxflag_pkg::WARN_LIMIT)
            |=> state_q.flags.receiver_state_field == rxflag_pkg::STATE_OK)
        else $error("receiver state not ok outside bus-off");

    a_sens_never: assert property (@(posedge pclk) disable iff (!presetn)
        (!state_q.flags.bus_status_change_flag &&
         state_q.enables.receiver_state_sensitivity == rxflag_pkg::SENS_NEVER &&
         state_q.enables.transmitter_state_sensitivity == rxflag_pkg::SENS_NEVER)
            |=> !state_q.flags.bus_status_change_flag)
        else $error("change flag set with both sensitivities off");

    a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_access && hit_enables && !in_init) |=> state_q.enables == $past(pwdata[7:0]))
        else $error("enable write did not land");

endmodule : can_rx_flags_and_irq_enables

//--- verif/rx_fifo_model.sv
// Purpose: Receive FIFO neighbour that feeds message shifts and overrun events.
// Assumes: Two entries wait behind the foreground buffer.
// Notes:   Each push is one received message; message_correct is the inverse of corrupt at the shift.
`timescale 1ns/1ns

module rx_fifo_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic push,
    input  wire logic corrupt,
    input  wire logic fifo_advance_allow,
    output logic      message_shift,
    output logic      message_correct,
    output logic      overrun_event
);
    logic [1:0] pending_q;
    logic       fire;
    logic       take;

    // The guard on message_shift stops a second shift before the full flag lands.
    assign fire = fifo_advance_allow && (pending_q != 2'h0) && !message_shift;
    assign take = push && (pending_q != 2'h2);
    assign message_correct = !corrupt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_q     <= 2'h0;
            message_shift <= 1'b0;
            overrun_event <= 1'b0;
        end else begin
            message_shift <= fire;
            overrun_event <= push && (pending_q == 2'h2);
            pending_q     <= pending_q + {1'b0, take} - {1'b0, fire};
        end
    end
endmodule : rx_fifo_model

//--- verif/test_can_rx_flags_and_irq_enables.sv
// Purpose: Register level test of the receiver flag and enable block.
// Assumes: Zero wait APB slave; offsets from the package.
// Notes:   Counters and events are driven by the bench and the FIFO model.
`timescale 1ns/1ns

module test_can_rx_flags_and_irq_enables;
    localparam logic [7:0] FL = rxflag_pkg::FLAGS_OFFSET;
    localparam logic [7:0] EN = rxflag_pkg::ENABLES_OFFSET;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic        pready, pslverr, fifo_advance_allow, wakeup_irq, error_irq, receive_irq;
    logic        init_req = 1'b0, init_ack = 1'b0, wakeup_event = 1'b0, push = 1'b0;
    logic [8:0]  tx = 9'h000, rx = 9'h000;
    logic        message_shift, message_correct, overrun_event;
    logic        corrupt = 1'b0;
    int          err_count = 0, checks_done = 0;

    always #2 pclk = ~pclk;

    can_rx_flags_and_irq_enables can_rx_flags_and_irq_enables_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .init_mode_request(init_req), .init_mode_acknowledge(init_ack),
        .tx_error_count(tx), .rx_error_count(rx), .wakeup_event(wakeup_event),
        .overrun_event(overrun_event), .message_shift(message_shift),
        .message_correct(message_correct), .fifo_advance_allow(fifo_advance_allow),
        .wakeup_irq(wakeup_irq), .error_irq(error_irq), .receive_irq(receive_irq));

    rx_fifo_model rx_fifo_model_inst (
        .pclk(pclk), .presetn(presetn), .push(push), .corrupt(corrupt),
        .fifo_advance_allow(fifo_advance_allow), .message_shift(message_shift),
        .message_correct(message_correct), .overrun_event(overrun_event));

    // ========================================================================
    // Tasks
    // ========================================================================
    task wrap_up;
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task chk1(input logic e, input string what);
        @(negedge pclk);
        if (what == "w") check({31'h0000_0000, wakeup_irq}, {31'h0000_0000, e});
        else if (what == "e") check({31'h0000_0000, error_irq}, {31'h0000_0000, e});
        else if (what == "r") check({31'h0000_0000, receive_irq}, {31'h0000_0000, e});
        else check({31'h0000_0000, fifo_advance_allow}, {31'h0000_0000, e});
    endtask : chk1

    // Each transfer starts at least one edge after the last, so no signal is driven twice at once.
    task apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task rc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        // A flag lands two edges after a push or a refill; read data is taken at setup.
        repeat (2) @(posedge pclk);
        apb(1'b0, a, 8'h00, q);
        check(q, {24'h00_0000, e});
    endtask : rc

    task pulse(input logic is_push);
        @(posedge pclk);
        if (is_push) push <= 1'b1;
        else wakeup_event <= 1'b1;
        @(posedge pclk);
        push <= 1'b0;
        wakeup_event <= 1'b0;
    endtask : pulse

    // ========================================================================
    // Tests
    // ========================================================================
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rc(EN, 8'h00);
        rc(FL, 8'h00);
        wr(EN, 8'hff);
        rc(EN, 8'hff);
        rc(8'h08, 8'h00);
        check({31'h0000_0000, pslverr}, 32'h0000_0000);
        $display("Test registers done");
        wr(EN, 8'h03);
        corrupt <= 1'b1;
        pulse(1'b1);
        rc(FL, 8'h00);
        corrupt <= 1'b0;
        pulse(1'b1);
        rc(FL, 8'h01);
        chk1(1'b1, "r");
        chk1(1'b0, "a");
        repeat (3) pulse(1'b1);
        rc(FL, 8'h03);
        chk1(1'b1, "e");
        wr(FL, 8'h00);
        rc(FL, 8'h03);
        wr(FL, 8'h01);
        rc(FL, 8'h03);
        wr(FL, 8'h03);
        rc(FL, 8'h01);
        wr(FL, 8'h01);
        rc(FL, 8'h00);
        chk1(1'b0, "r");
        $display("Test receive fifo done");
        wr(EN, 8'h00);
        pulse(1'b0);
        rc(FL, 8'h80);
        chk1(1'b0, "w");
        wr(EN, 8'h80);
        chk1(1'b1, "w");
        wr(FL, 8'h80);
        rc(FL, 8'h00);
        $display("Test wakeup done");
        wr(EN, 8'h4c);
        tx <= 9'h061;
        rc(FL, 8'h44);
        chk1(1'b1, "e");
        tx <= 9'h080;
        rc(FL, 8'h44);
        wr(FL, 8'h40);
        rc(FL, 8'h48);
        wr(FL, 8'h3c);
        rc(FL, 8'h48);
        wr(FL, 8'h40);
        rc(FL, 8'h08);
        wr(EN, 8'h40);
        tx <= 9'h061;
        rx <= 9'h064;
        rc(FL, 8'h14);
        chk1(1'b0, "e");
        wr(EN, 8'h44);
        tx <= 9'h080;
        rc(FL, 8'h18);
        tx <= 9'h100;
        rc(FL, 8'h7c);
        tx <= 9'h000;
        rx <= 9'h000;
        wr(FL, 8'h40);
        rc(FL, 8'h40);
        wr(FL, 8'h40);
        rc(FL, 8'h00);
        wr(EN, 8'h60);
        rx <= 9'h064;
        rc(FL, 8'h10);
        rx <= 9'h080;
        rc(FL, 8'h60);
        chk1(1'b1, "e");
        rx <= 9'h000;
        wr(FL, 8'h40);
        rc(FL, 8'h40);
        wr(FL, 8'h40);
        rc(FL, 8'h00);
        $display("Test bus status done");
        wr(EN, 8'hfc);
        tx <= 9'h061;
        rc(FL, 8'h44);
        init_req <= 1'b1;
        init_ack <= 1'b1;
        rc(FL, 8'h04);
        rc(EN, 8'h3c);
        wr(EN, 8'h00);
        rc(EN, 8'h3c);
        init_req <= 1'b0;
        init_ack <= 1'b0;
        wr(EN, 8'h03);
        rc(EN, 8'h03);
        $display("Test init mode done");
        wrap_up();
    end

    // The tests take about 260 cycles; this limit leaves a wide margin.
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end
endmodule : test_can_rx_flags_and_irq_enables
